// ==== verilog/tpg_pkg.sv ====
package tpg_pkg;

    // register map, 32-bit aligned words
    localparam int          APB_AW        = 12;
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] STATUS_OFS    = 12'h004;

    // control fields
    localparam int          CTRL_BURST    = 0;
    localparam int          CTRL_ODD      = 1;
    localparam int          CTRL_SEVEN    = 2;
    localparam int          CTRL_W        = 3;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    // status fields
    localparam int          ST_COUNT_LSB  = 0;
    localparam int          ST_OE         = 4;
    localparam int          ST_WSTAT      = 5;
    localparam int          ST_RSTPEND    = 6;
    localparam int          ST_STARTDLY   = 7;

    // character counter
    localparam logic [3:0]  CHAR_LAST     = 4'h9;
    localparam int          NUM_SLOTS     = 10;
    localparam logic [2:0]  RESET_TICKS   = 3'h4;

    // timing, clock period 5 ns
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          WCLK_DELAY_NS = 400;
    localparam int          PULSE_US      = 2;
    localparam int          START_DLY_MS  = 50;
    localparam int          WCLK_DELAY_CYC =
        (WCLK_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          PULSE_CYC     = (PULSE_US * 1000000) / CLK_PERIOD_PS;
    localparam longint      START_DLY_CYC =
        (START_DLY_MS * 64'd1000000000) / CLK_PERIOD_PS;

    localparam int          FIFO_DEPTH    = 8;

    typedef struct packed {
        logic       parity;
        logic [7:0] data;
    } tpg_char_s;

    typedef enum logic [2:0] {
        BST_IDLE,
        BST_START,
        BST_RUN,
        BST_RST_WAIT,
        BST_RST_PULSE
    } tpg_burst_e;

endpackage : tpg_pkg

// ==== verilog/tpg_top.sv ====
// Behaviour
// - each master clock tick with no character pending steps a four-bit counter 0..9, then wraps to zero.
// - counter decodes into ten exclusive character gates for the pattern source.
// - count equals slot minus one, plain binary; tenth tick returns to zero.
// - each counter step starts a 400 ns delay before the write clock.
// - after the delay, one 2 us write clock pulse per character.
// - parity set for even ones with odd select, or odd ones with even select.
// - continuous mode: counter free-running, output enable always on.
// - continuous mode: write-reset delay, counter and pulse held cleared.
// - parity, data and write clock reach outputs only while output enabled.
// - status indicator lit while write-current status input is low.
// - falling edge of burst gate starts a 50 ms start delay.
// - during start delay: count forced nine, delay stage reset, outputs off.
// - delay expiry releases counter and enables outputs until gate ends.
// - write-reset generator held cleared while the burst gate is asserted.
// - gate rising edge stops counter and outputs, then counts four ticks.
// - after the fourth tick, one 2 us active-low write-reset pulse.
// - seven-track format leaves data bits zero and one unused.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module tpg_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         flush,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [W-1:0] mem_d [D];
    logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
    logic         push, pop;

    assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        if (flush) begin
            rd_d = wr_q;
        end else begin
            if (push) begin
                mem_d[wr_q[AW-1:0]] = in_data;
                wr_d = wr_q + 1'b1;
            end
            if (pop) begin
                rd_d = rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < D; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
        end
    end
endmodule : tpg_fifo

module tpg_top
    import tpg_pkg::*;
#(
    parameter int unsigned START_CYC = 32'(tpg_pkg::START_DLY_CYC)
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // master clock and tester gate, asynchronous pins
    input  wire logic        master_clk,
    input  wire logic        write_burst_gate_n,
    input  wire logic        write_current_status_n,
    // pattern source
    output logic [9:0]       char_gate,
    input  wire logic [7:0]  pattern_char,
    // tape unit write side
    output logic             write_parity_bit,
    output logic [7:0]       write_data,
    output logic             write_clock_out,
    output logic             write_reset_pulse_n,
    output logic             write_status_led
);
    import tpg_pkg::*;

    localparam int SYNC_W = 11;

    logic [SYNC_W-1:0] sync1_q, sync2_q;
    logic              mclk_prev_q, gate_prev_q;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic              pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]       prdata_q, prdata_d;
    logic [3:0]        count_q, count_d;
    logic [9:0]        gate_q, gate_d;
    logic [6:0]        dly_q, dly_d;
    logic              busy_q, busy_d;
    logic [8:0]        wclk_cnt_q, wclk_cnt_d;
    logic              wclk_q, wclk_d;
    tpg_char_s         out_q, out_d;
    tpg_burst_e        state_q, state_d;
    logic [23:0]       start_q, start_d;
    logic [2:0]        ticks_q, ticks_d;
    logic [8:0]        rst_cnt_q, rst_cnt_d;
    logic              rstp_n_q, rstp_n_d;
    logic              led_q;

    logic              mclk_s, gate_s, wstat_s, tick, gate_fall, gate_rise;
    logic [7:0]        char_s, char_m;
    logic              burst, oe, push_ok, fifo_in_ready, fifo_out_valid, pop;
    tpg_char_s         fifo_out;
    logic              wr_en;

    function automatic logic parity_of(input logic [7:0] c, input logic odd_sel);
        parity_of = (^c) ^ odd_sel;
    endfunction : parity_of

    // pins cross in through two flops; edge logic reads only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // both stages reset to the idle pin levels, so no false gate edge follows reset
            sync1_q     <= {3'h3, 8'h00};
            sync2_q     <= {3'h3, 8'h00};
            mclk_prev_q <= 1'b0;
            gate_prev_q <= 1'b1;
            led_q       <= 1'b0;
        end else begin
            sync1_q     <= {master_clk, write_burst_gate_n, write_current_status_n,
                            pattern_char};
            sync2_q     <= sync1_q;
            mclk_prev_q <= mclk_s;
            gate_prev_q <= gate_s;
            led_q       <= ~wstat_s;
        end
    end

    assign mclk_s    = sync2_q[10];
    assign gate_s    = sync2_q[9];
    assign wstat_s   = sync2_q[8];
    assign char_s    = sync2_q[7:0];
    assign tick      = mclk_s && !mclk_prev_q;
    assign gate_fall = gate_prev_q && !gate_s;
    assign gate_rise = !gate_prev_q && gate_s;
    assign burst     = ctrl_q[CTRL_BURST];
    assign oe        = !burst || (state_q == BST_RUN);

    // apb: one wait state, answer on the second access cycle
    assign wr_en = psel && penable && pready_q && pwrite;

    always_comb begin
        ctrl_d    = ctrl_q;
        pready_d  = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        prdata_d  = '0;
        if (pready_d) begin
            unique case (paddr)
                CTRL_OFS: begin
                    prdata_d[CTRL_W-1:0] = ctrl_q;
                end
                STATUS_OFS: begin
                    prdata_d[ST_COUNT_LSB +: 4] = count_q;
                    prdata_d[ST_OE]             = oe;
                    prdata_d[ST_WSTAT]          = led_q;
                    prdata_d[ST_RSTPEND]        = (state_q == BST_RST_WAIT) ||
                                                  (state_q == BST_RST_PULSE);
                    prdata_d[ST_STARTDLY]       = (state_q == BST_START);
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (wr_en && paddr == CTRL_OFS) begin
            ctrl_d = pwdata[CTRL_W-1:0];
        end
    end

    // burst sequencing
    always_comb begin
        state_d   = state_q;
        start_d   = start_q;
        ticks_d   = ticks_q;
        rst_cnt_d = rst_cnt_q;
        rstp_n_d  = 1'b1;
        if (!burst) begin
            state_d   = BST_IDLE;
            start_d   = '0;
            ticks_d   = '0;
            rst_cnt_d = '0;
        end else if (gate_fall) begin
            state_d   = BST_START;
            start_d   = 24'(START_CYC - 1);
            ticks_d   = '0;
            rst_cnt_d = '0;
        end else begin
            unique case (state_q)
                BST_IDLE: begin
                    ticks_d = '0;
                end
                BST_START: begin
                    if (gate_rise) begin
                        state_d = BST_RST_WAIT;
                    end else if (start_q == '0) begin
                        state_d = BST_RUN;
                    end else begin
                        start_d = start_q - 1'b1;
                    end
                end
                BST_RUN: begin
                    if (gate_rise) begin
                        state_d = BST_RST_WAIT;
                        ticks_d = '0;
                    end
                end
                BST_RST_WAIT: begin
                    if (tick) begin
                        ticks_d = ticks_q + 1'b1;
                        if (ticks_q == RESET_TICKS - 3'h1) begin
                            state_d   = BST_RST_PULSE;
                            rst_cnt_d = 9'(PULSE_CYC - 1);
                            rstp_n_d  = 1'b0;
                        end
                    end
                end
                BST_RST_PULSE: begin
                    if (rst_cnt_q == '0) begin
                        state_d = BST_IDLE;
                        ticks_d = '0;
                    end else begin
                        rst_cnt_d = rst_cnt_q - 1'b1;
                        rstp_n_d  = 1'b0;
                    end
                end
            endcase
        end
    end

    // character counter, gates and capture delay
    assign char_m  = ctrl_q[CTRL_SEVEN] ? {char_s[7:2], 2'b00} : char_s;
    assign push_ok = busy_q && oe && (dly_q == '0);

    always_comb begin
        count_d = count_q;
        dly_d   = dly_q;
        busy_d  = busy_q;
        if (burst && state_q == BST_START) begin
            count_d = CHAR_LAST;
            busy_d  = 1'b0;
            dly_d   = '0;
        end else if (!oe) begin
            busy_d  = 1'b0;
            dly_d   = '0;
        end else if (tick && !busy_q) begin
            // a tick that lands while a character is still pending is dropped
            count_d = (count_q == CHAR_LAST) ? 4'h0 : count_q + 4'h1;
            busy_d  = 1'b1;
            dly_d   = 7'(WCLK_DELAY_CYC - 1);
        end else if (busy_q && dly_q != '0) begin
            dly_d   = dly_q - 1'b1;
        end else if (push_ok && fifo_in_ready) begin
            busy_d  = 1'b0;
        end
    end

    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_gate
        assign gate_d[i] = (count_d == 4'(i));
    end

    tpg_fifo #(
        .W ($bits(tpg_char_s)),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (!oe),
        .in_valid  (push_ok),
        .in_ready  (fifo_in_ready),
        .in_data   ({parity_of(char_m, ctrl_q[CTRL_ODD]), char_m}),
        .out_valid (fifo_out_valid),
        .out_ready (wclk_cnt_q == '0),
        .out_data  (fifo_out)
    );

    // output stage stalls the fifo for the length of each write clock pulse
    assign pop = fifo_out_valid && (wclk_cnt_q == '0) && oe;

    always_comb begin
        out_d      = out_q;
        wclk_cnt_d = wclk_cnt_q;
        wclk_d     = wclk_q;
        if (!oe) begin
            out_d      = '0;
            wclk_cnt_d = '0;
            wclk_d     = 1'b0;
        end else if (pop) begin
            out_d      = fifo_out;
            wclk_cnt_d = 9'(PULSE_CYC);
            wclk_d     = 1'b1;
        end else if (wclk_cnt_q != '0) begin
            wclk_cnt_d = wclk_cnt_q - 1'b1;
            wclk_d     = (wclk_cnt_q != 9'h1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q     <= CTRL_RESET;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            prdata_q   <= '0;
            count_q    <= '0;
            gate_q     <= 10'h001;
            dly_q      <= '0;
            busy_q     <= 1'b0;
            wclk_cnt_q <= '0;
            wclk_q     <= 1'b0;
            out_q      <= '0;
            state_q    <= BST_IDLE;
            start_q    <= '0;
            ticks_q    <= '0;
            rst_cnt_q  <= '0;
            rstp_n_q   <= 1'b1;
        end else begin
            ctrl_q     <= ctrl_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            prdata_q   <= prdata_d;
            count_q    <= count_d;
            gate_q     <= gate_d;
            dly_q      <= dly_d;
            busy_q     <= busy_d;
            wclk_cnt_q <= wclk_cnt_d;
            wclk_q     <= wclk_d;
            out_q      <= out_d;
            state_q    <= state_d;
            start_q    <= start_d;
            ticks_q    <= ticks_d;
            rst_cnt_q  <= rst_cnt_d;
            rstp_n_q   <= rstp_n_d;
        end
    end

    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign prdata              = prdata_q;
    assign char_gate           = gate_q;
    assign write_parity_bit    = out_q.parity;
    assign write_data          = out_q.data;
    assign write_clock_out     = wclk_q;
    assign write_reset_pulse_n = rstp_n_q;
    assign write_status_led    = led_q;

endmodule : tpg_top

// ==== testbench/tpg_top_sva.sv ====
`timescale 1ns/1ps
module tpg_top_sva
    import tpg_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // pins
    input wire logic        write_burst_gate_n,
    input wire logic        write_current_status_n,
    input wire logic [9:0]  char_gate,
    input wire logic        write_parity_bit,
    input wire logic [7:0]  write_data,
    input wire logic        write_clock_out,
    input wire logic        write_reset_pulse_n,
    input wire logic        write_status_led
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [2:0]  ctrl_q, ctrl_d;
    logic [11:0] age_q, age_d;
    logic [9:0]  gate_q;
    logic [8:0]  wlen_q, wlen_d, rs_q, rs_d;
    logic        ctrl_wr;

    // characters already queued under an old setting are not judged
    always_comb begin
        ctrl_wr = psel && penable && pready && pwrite && paddr == CTRL_OFS;
        ctrl_d  = ctrl_wr ? pwdata[2:0] : ctrl_q;
        age_d   = ctrl_wr ? 12'h000 : (&age_q ? age_q : age_q + 12'h001);
        wlen_d  = write_clock_out ? wlen_q + 9'h001 : 9'h000;
        rs_d    = write_reset_pulse_n ? 9'h000 : rs_q + 9'h001;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RESET;
            age_q  <= 12'h000;
            gate_q <= 10'h001;
            wlen_q <= 9'h000;
            rs_q   <= 9'h000;
        end else begin
            ctrl_q <= ctrl_d;
            age_q  <= age_d;
            gate_q <= char_gate;
            wlen_q <= wlen_d;
            rs_q   <= rs_d;
        end
    end

    chk_gate_onehot: assert property ($onehot(char_gate))
        else $error("char gate not one-hot");
    chk_gate_step: assert property (!ctrl_q[CTRL_BURST] && char_gate != gate_q |->
        char_gate == {gate_q[8:0], gate_q[9]}) else $error("count step wrong");
    chk_wclk_width: assert property ($fell(write_clock_out) &&
        (!ctrl_q[CTRL_BURST] || !write_burst_gate_n) |-> wlen_q == 9'(PULSE_CYC))
        else $error("write clock width wrong");
    chk_rst_width: assert property ($rose(write_reset_pulse_n) && write_burst_gate_n
        |-> rs_q == 9'(PULSE_CYC)) else $error("reset pulse width wrong");
    chk_no_rst_cont: assert property (!ctrl_q[CTRL_BURST] |-> write_reset_pulse_n)
        else $error("reset pulse in continuous mode");
    chk_no_rst_gate: assert property ((!write_burst_gate_n)[*6] |-> write_reset_pulse_n)
        else $error("reset pulse during burst");
    chk_led_on: assert property ((!write_current_status_n)[*5] |-> write_status_led)
        else $error("status led off");
    chk_led_off: assert property (write_current_status_n[*5] |-> !write_status_led)
        else $error("status led on");
    chk_parity_val: assert property ($rose(write_clock_out) && &age_q |->
        write_parity_bit == (^write_data ^ ctrl_q[CTRL_ODD])) else $error("parity wrong");
    chk_seven_zero: assert property ($rose(write_clock_out) && &age_q &&
        ctrl_q[CTRL_SEVEN] |-> write_data[1:0] == 2'h0) else $error("track bits used");
    chk_out_off: assert property ((ctrl_q[CTRL_BURST] && write_burst_gate_n)[*8] |->
        !write_clock_out && write_data == 8'h00 && !write_parity_bit)
        else $error("outputs not off");

    cover property ($rose(write_clock_out));
    cover property ($fell(write_reset_pulse_n));
    cover property ($rose(write_status_led));
endmodule : tpg_top_sva

// ==== testbench/tpg_tape_model.sv ====
`timescale 1ns/1ps
module tpg_tape_model
    import tpg_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // pattern source
    input  wire logic [9:0] char_gate,
    output logic [7:0]      pattern_char,
    // tape write side
    input  wire logic       write_parity_bit,
    input  wire logic [7:0] write_data,
    input  wire logic       write_clock_out,
    input  wire logic       write_reset_pulse_n,
    output logic            write_current_status_n,
    // bench control and observation
    input  wire logic       head_on,
    output int              chars_seen,
    output int              resets_seen,
    output tpg_char_s       last_char
);
    logic      wclk_prev_q;
    logic      rs_q;
    tpg_char_s lrc_q;

    assign write_current_status_n = !head_on;

    always_comb begin
        pattern_char = 8'h00;
        for (int k = 0; k < NUM_SLOTS; k++)
            if (char_gate[k]) pattern_char = 8'(k * 37 + 3);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wclk_prev_q <= 1'b0;
            rs_q        <= 1'b1;
            chars_seen  <= 0;
            resets_seen <= 0;
            last_char   <= '0;
            lrc_q       <= '0;
        end else begin
            wclk_prev_q <= write_clock_out;
            rs_q <= write_reset_pulse_n;
            if (write_clock_out && !wclk_prev_q) begin
                chars_seen <= chars_seen + 1;
                last_char  <= {write_parity_bit, write_data};
                lrc_q      <= lrc_q ^ {write_parity_bit, write_data};
            end
            // write reset pulse clears the running xor of all characters, then a new block starts
            if (!write_reset_pulse_n && rs_q) begin
                resets_seen <= resets_seen + 1;
                lrc_q       <= '0;
            end
        end
    end
endmodule : tpg_tape_model

// ==== testbench/tpg_top_tb.sv ====
`timescale 1ns/1ps
module tpg_top_tb;
    import tpg_pkg::*;

    localparam int unsigned START = 200;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr;
    logic [31:0] prdata, q;
    logic        master_clk = 1'b0;
    logic        write_burst_gate_n = 1'b1;
    logic        head_on = 1'b0;
    logic        write_current_status_n, write_parity_bit, write_clock_out;
    logic        write_reset_pulse_n, write_status_led, e;
    logic [9:0]  char_gate;
    logic [7:0]  pattern_char, write_data;
    tpg_char_s   last_char;
    int          chars_seen, resets_seen;
    int          errors = 0;
    int          total_checks = 0;
    int          mhalf = 250;
    int          mticks = 0;
    int          cyc = 0;

    tpg_top #(.START_CYC(START)) dut_u (.*);
    tpg_tape_model tape_u (.*);

    always #2.5 clk = ~clk;
    always @(posedge clk) cyc++;
    always @(posedge master_clk) mticks++;
    // master clock stays on clk edges so every drive is a clean nba
    always begin
        repeat (mhalf) @(posedge clk);
        master_clk <= ~master_clk;
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_lvl(ref logic s, input logic v, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== v && n < 3000);
        if (n >= 3000) check("wait", 0, 1);
    endtask : wait_lvl

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) check("pready", 1, 0);
    endtask : apb

    task automatic t_regs;
        apb(0, CTRL_OFS, 0);
        check("ctrl", 0, q);
        apb(0, STATUS_OFS, 0);
        check("oe", 1, 32'(q[ST_OE]));
        apb(1, 12'h040, 32'h7);
        check("slverr", 1, 32'(e));
        apb(0, CTRL_OFS, 0);
        check("ctrl kept", 0, q);
        $display("regs test done");
    endtask : t_regs

    task automatic t_count(input logic [2:0] c);
        int s, n;
        logic [7:0] d;
        apb(1, CTRL_OFS, 32'(c));
        repeat (1200) @(posedge clk);
        wait_lvl(write_clock_out, 1, n);
        s = $clog2(char_gate);
        for (int i = 1; i <= 11; i++) begin
            wait_lvl(master_clk, 0, n);
            wait_lvl(master_clk, 1, n);
            wait_lvl(write_clock_out, 1, n);
            check("wclk delay", 1, 32'(n >= 80 && n <= 90));
            check("gate", 32'(10'h001 << ((s + i) % 10)), 32'(char_gate));
            @(posedge clk);
            d = 8'(((s + i) % 10) * 37 + 3) & (c[CTRL_SEVEN] ? 8'hfc : 8'hff);
            check("data", 32'(d), 32'(last_char.data));
            check("parity", 32'(^d ^ c[CTRL_ODD]), 32'(last_char.parity));
        end
        apb(0, STATUS_OFS, 0);
        check("count", 32'((s + 1) % 10), 32'(q[3:0]));
        $display("count test done");
    endtask : t_count

    task automatic t_fast;
        int c0;
        mhalf = 8;
        repeat (4000) @(posedge clk);
        c0 = chars_seen;
        repeat (4000) @(posedge clk);
        check("fast rate", 1, 32'((chars_seen - c0) inside {[9:10]}));
        mhalf = 250;
        repeat (4000) @(posedge clk);
        $display("fast test done");
    endtask : t_fast

    task automatic t_led;
        head_on <= 1'b1;
        repeat (6) @(posedge clk);
        check("led on", 1, 32'(write_status_led));
        apb(0, STATUS_OFS, 0);
        check("led status bit", 1, 32'(q[ST_WSTAT]));
        head_on <= 1'b0;
        repeat (6) @(posedge clk);
        check("led off", 0, 32'(write_status_led));
        $display("led test done");
    endtask : t_led

    task automatic t_burst;
        int n, t0, m0, c1, r0;
        apb(1, CTRL_OFS, 32'h1);
        repeat (4000) @(posedge clk);
        r0 = resets_seen;
        write_burst_gate_n <= 1'b0;
        t0 = cyc;
        repeat (20) @(posedge clk);
        check("nine", 32'h200, 32'(char_gate));
        check("wclk held", 0, 32'(write_clock_out));
        apb(0, STATUS_OFS, 0);
        check("start delay", 1, 32'(q[ST_STARTDLY]));
        wait_lvl(write_clock_out, 1, n);
        check("delay span", 1, 32'(cyc - t0 >= START));
        check("first slot", 32'h001, 32'(char_gate));
        wait_lvl(write_clock_out, 0, n);
        wait_lvl(write_clock_out, 1, n);
        @(posedge clk);
        c1 = chars_seen;
        write_burst_gate_n <= 1'b1;
        m0 = mticks;
        wait_lvl(write_reset_pulse_n, 0, n);
        check("ticks to reset", 4, mticks - m0);
        wait_lvl(write_reset_pulse_n, 1, n);
        repeat (3000) @(posedge clk);
        check("one reset", r0 + 1, resets_seen);
        check("chars stopped", c1, chars_seen);
        $display("burst test done");
    endtask : t_burst

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_count(3'h0);
        t_count(3'h6);
        t_fast();
        t_led();
        t_burst();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule : tpg_top_tb

bind tpg_top tpg_top_sva chk_u (.*);
